// file: rtl/tcc_top.sv
// Purpose: five-channel 16-bit timer counters with compare/capture and buffer registers
// Assumes: clk_sys is the internal clock phi; pins arrive asynchronously
// Notes:   pwm waveform shaping and output master enables are not part of this block
// Function
// - each of five channels has its own 16-bit counter
// - channels 0 and 1 count up only
// - channel 2 counts up or down in phase counting, else up
// - channels 3 and 4 count up/down in complementary pwm, else up
// - counter advances on ticks from the three-bit clock select source
// - counter may clear on register A or B match or capture
// - up wrap from all ones to zero sets the wrap flag
// - down wrap from zero to all ones sets the wrap flag
// - counters, general and buffer registers read/write by word or byte
// - counters go to zero on reset and standby
// - two general registers per channel, compare or capture per io control
// - compare equality sets match flag and may drive the compare output
// - capture latches counter on selected edge and sets flag together
// - io control ignored in pwm mode, and on channels 3 and 4 in complementary and reset-sync pwm modes
// - general registers reset to compare, no output, all ones
// - channels 3 and 4 have two buffers, each enabled separately
// - buffer acts as compare buffer when paired register compares
// - buffer acts as capture buffer when paired register captures
// - buffer registers go to all ones on reset and standby
// - internal phi to phi/8 when select top bit clear, else external pins
// - clear select picks none, A, B or synchronous clear
`timescale 1ns/10ps
`include "tcc_consts.svh"
`default_nettype none

module tcc_top
  import tcc_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          standby,
  input  wire tcc_bus_req_s  bus_req,
  output logic [15:0]        bus_rdata,
  output logic               bus_rvalid,
  input  wire logic [3:0]    ext_clk_pin,
  input  wire logic [4:0]    cap_a_pin,
  input  wire logic [4:0]    cap_b_pin,
  output logic [9:0]         cmp_out,
  output logic [9:0]         cmp_oe
);

  localparam tcc_state_s ST_RST = '{
    cnt:     {5{`TCC_RST_CNT}},
    general_register_a:     {5{`TCC_RST_GR}},
    general_register_b:     {5{`TCC_RST_GR}},
    buffer_register_a:     {2{`TCC_RST_BR}},
    buffer_register_b:     {2{`TCC_RST_BR}},
    timer_control_register:     {5{`TCC_RST_TCR}},
    io_control_register:    {5{`TCC_RST_IO_CONTROL_REGISTER}},
    default: '0
  };

  tcc_state_s  r;
  tcc_state_s  n;
  logic [13:0] pins;
  logic [13:0] rise;
  logic [13:0] fall;
  logic [4:0]  tick;
  logic [4:0]  dn;
  logic [4:0]  pwm_any;
  logic [4:0]  cmp_a;
  logic [4:0]  cmp_b;
  logic [4:0]  mat_a;
  logic [4:0]  mat_b;
  logic [4:0]  cpa;
  logic [4:0]  cpb;
  logic [4:0]  own_clr;
  logic [4:0]  clr;
  logic [4:0]  ch_wr;
  logic [4:0]  buf_a;
  logic [4:0]  buf_b;
  logic [2:0]  ch_sel;
  logic [2:0]  reg_sel;

  assign pins    = {cap_b_pin, cap_a_pin, ext_clk_pin};
  assign ch_sel  = bus_req.addr[5:3];
  assign reg_sel = bus_req.addr[2:0];
  assign buf_a   = {r.bfen[2], r.bfen[0], 3'h0};
  assign buf_b   = {r.bfen[3], r.bfen[1], 3'h0};

  assign bus_rdata  = r.rdata;
  assign bus_rvalid = r.rvalid;
  assign cmp_out    = r.out_lvl;
  assign cmp_oe     = r.out_oe;

  function automatic logic [15:0] tcc_bw(input logic [15:0] old_v,
                                         input logic [15:0] wd,
                                         input logic [1:0]  be);
    tcc_bw = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // count ticks, compare and capture events

  always_comb begin
    // a level counts only once the last two sync stages agree
    rise    = r.s2 & r.s3 & ~r.lvl;
    fall    = ~r.s2 & ~r.s3 & r.lvl;
    own_clr = '0;
    for (int c = 0; c < 5; c++) begin
      ch_wr[c]   = bus_req.wr && (ch_sel == c[2:0]);
      pwm_any[c] = r.mode[c] ||
                   (c >= 3 && (r.mode[`TCC_MODE_CPWM] || r.mode[`TCC_MODE_RSPWM]));
      if (!r.timer_control_register[c][`TCC_TCR_EXT]) begin
        case (r.timer_control_register[c][1:0])
          2'h0:    tick[c] = 1'b1;
          2'h1:    tick[c] = r.presc[0];
          2'h2:    tick[c] = &r.presc[1:0];
          default: tick[c] = &r.presc;
        endcase
      end else if (r.timer_control_register[c][`TCC_TCR_EDGE_BOTH]) begin
        tick[c] = rise[r.timer_control_register[c][1:0]] | fall[r.timer_control_register[c][1:0]];
      end else if (r.timer_control_register[c][`TCC_TCR_EDGE_FALL]) begin
        tick[c] = fall[r.timer_control_register[c][1:0]];
      end else begin
        tick[c] = rise[r.timer_control_register[c][1:0]];
      end
      dn[c] = 1'b0;
      if (c == 2 && r.mode[`TCC_MODE_PHASE]) begin
        // x1 decode: edge A counts, level B picks direction
        tick[c] = rise[0];
        dn[c]   = r.lvl[1];
      end
      if (c >= 3 && r.mode[`TCC_MODE_CPWM]) begin
        dn[c] = r.down[c];
      end
      cmp_a[c] = pwm_any[c] || !r.io_control_register[c][`TCC_IO_CONTROL_REGISTER_CAP_A];
      cmp_b[c] = pwm_any[c] || !r.io_control_register[c][`TCC_IO_CONTROL_REGISTER_CAP_B];
      mat_a[c] = cmp_a[c] && tick[c] && (r.cnt[c] == r.general_register_a[c]);
      mat_b[c] = cmp_b[c] && tick[c] && (r.cnt[c] == r.general_register_b[c]);
      case (r.io_control_register[c][1:0])
        2'h0:    cpa[c] = !cmp_a[c] && rise[4 + c];
        2'h1:    cpa[c] = !cmp_a[c] && fall[4 + c];
        default: cpa[c] = !cmp_a[c] && (rise[4 + c] || fall[4 + c]);
      endcase
      case (r.io_control_register[c][5:4])
        2'h0:    cpb[c] = !cmp_b[c] && rise[9 + c];
        2'h1:    cpb[c] = !cmp_b[c] && fall[9 + c];
        default: cpb[c] = !cmp_b[c] && (rise[9 + c] || fall[9 + c]);
      endcase
      case (r.timer_control_register[c][`TCC_TCR_CLR_HI:`TCC_TCR_CLR_LO])
        2'h1:    own_clr[c] = mat_a[c] || cpa[c];
        2'h2:    own_clr[c] = mat_b[c] || cpb[c];
        default: own_clr[c] = 1'b0;
      endcase
    end
    clr = own_clr;
    for (int c = 0; c < 5; c++) begin
      if (r.timer_control_register[c][`TCC_TCR_CLR_HI:`TCC_TCR_CLR_LO] == 2'h3 &&
          r.mode[`TCC_MODE_SYNC_LO + c] &&
          |(own_clr & r.mode[`TCC_MODE_SYNC_LO +: 5])) begin
        clr[c] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n        = r;
    n.s1     = pins;
    n.s2     = r.s1;
    n.s3     = r.s2;
    n.lvl    = (r.s2 == r.s3) ? r.s2 : r.lvl;
    n.presc  = r.presc + 3'h1;
    n.rvalid = 1'b0;
    for (int c = 0; c < 5; c++) begin
      if (clr[c]) begin
        n.cnt[c] = `TCC_RST_CNT;
      end else if (tick[c]) begin
        n.cnt[c] = dn[c] ? r.cnt[c] - 16'h0001 : r.cnt[c] + 16'h0001;
      end
      if (c >= 3) begin
        if (!r.mode[`TCC_MODE_CPWM]) begin
          n.down[c] = 1'b0;
        end else if (tick[c] && !dn[c] && r.cnt[c] == r.general_register_a[c]) begin
          n.down[c] = 1'b1;
        end else if (tick[c] && dn[c] && r.cnt[c] == `TCC_RST_CNT) begin
          n.down[c] = 1'b0;
        end
      end
      if (cpa[c]) begin
        n.general_register_a[c] = r.cnt[c];
      end
      if (cpb[c]) begin
        n.general_register_b[c] = r.cnt[c];
      end
      // pwm waveform is handled elsewhere, so pins float in pwm modes
      n.out_oe[c]     = !pwm_any[c] && cmp_a[c] && (r.io_control_register[c][1:0] != 2'h0);
      n.out_oe[5 + c] = !pwm_any[c] && cmp_b[c] && (r.io_control_register[c][5:4] != 2'h0);
      if (n.out_oe[c] && mat_a[c]) begin
        case (r.io_control_register[c][1:0])
          2'h1:    n.out_lvl[c] = 1'b0;
          2'h2:    n.out_lvl[c] = 1'b1;
          default: n.out_lvl[c] = (c == 2) ? 1'b1 : !r.out_lvl[c];
        endcase
      end
      if (n.out_oe[5 + c] && mat_b[c]) begin
        case (r.io_control_register[c][5:4])
          2'h1:    n.out_lvl[5 + c] = 1'b0;
          2'h2:    n.out_lvl[5 + c] = 1'b1;
          default: n.out_lvl[5 + c] = (c == 2) ? 1'b1 : !r.out_lvl[5 + c];
        endcase
      end
    end
    for (int b = 0; b < 2; b++) begin
      if (cpa[3 + b] && buf_a[3 + b]) begin
        n.buffer_register_a[b] = r.general_register_a[3 + b];
      end
      if (mat_a[3 + b] && buf_a[3 + b]) begin
        n.general_register_a[3 + b] = r.buffer_register_a[b];
      end
      if (cpb[3 + b] && buf_b[3 + b]) begin
        n.buffer_register_b[b] = r.general_register_b[3 + b];
      end
      if (mat_b[3 + b] && buf_b[3 + b]) begin
        n.general_register_b[3 + b] = r.buffer_register_b[b];
      end
    end
    // cpu write beats a same-cycle count or capture
    if (bus_req.wr && ch_sel < `TCC_NUM_CH) begin
      case (reg_sel)
        `TCC_REG_CTRL: begin
          if (bus_req.be[0]) n.timer_control_register[ch_sel] = bus_req.wdata[7:0] | `TCC_RST_TCR;
          if (bus_req.be[1]) n.io_control_register[ch_sel] = bus_req.wdata[15:8] | `TCC_RST_IO_CONTROL_REGISTER;
        end
        `TCC_REG_STAT: begin
          if (bus_req.be[0]) n.timer_status_register[ch_sel] = r.timer_status_register[ch_sel] & bus_req.wdata[2:0];
        end
        `TCC_REG_CNT: n.cnt[ch_sel] = tcc_bw(r.cnt[ch_sel], bus_req.wdata, bus_req.be);
        `TCC_REG_GRA: n.general_register_a[ch_sel] = tcc_bw(r.general_register_a[ch_sel], bus_req.wdata, bus_req.be);
        `TCC_REG_GRB: n.general_register_b[ch_sel] = tcc_bw(r.general_register_b[ch_sel], bus_req.wdata, bus_req.be);
        `TCC_REG_BRA: begin
          if (ch_sel >= 3'h3) begin
            n.buffer_register_a[~ch_sel[0]] = tcc_bw(r.buffer_register_a[~ch_sel[0]], bus_req.wdata, bus_req.be);
          end
        end
        `TCC_REG_BRB: begin
          if (ch_sel >= 3'h3) begin
            n.buffer_register_b[~ch_sel[0]] = tcc_bw(r.buffer_register_b[~ch_sel[0]], bus_req.wdata, bus_req.be);
          end
        end
        default: ;
      endcase
    end else if (bus_req.wr && ch_sel == `TCC_GLB_CH) begin
      if (reg_sel == `TCC_GLB_FUNC && bus_req.be[0]) begin
        n.bfen = bus_req.wdata[3:0];
      end
      if (reg_sel == `TCC_GLB_MODE) begin
        n.mode = 13'(tcc_bw({3'h0, r.mode}, bus_req.wdata, bus_req.be));
      end
    end
    // set beats the software clear in the same cycle
    for (int c = 0; c < 5; c++) begin
      n.timer_status_register[c][`TCC_TSR_MCA] = n.timer_status_register[c][`TCC_TSR_MCA] | mat_a[c] | cpa[c];
      n.timer_status_register[c][`TCC_TSR_MCB] = n.timer_status_register[c][`TCC_TSR_MCB] | mat_b[c] | cpb[c];
      if (tick[c] && !clr[c] && !dn[c] && r.cnt[c] == `TCC_CNT_ONES) begin
        n.timer_status_register[c][`TCC_TSR_WRAP] = 1'b1;
      end
      if (tick[c] && !clr[c] && dn[c] && r.cnt[c] == `TCC_RST_CNT) begin
        n.timer_status_register[c][`TCC_TSR_WRAP] = 1'b1;
      end
    end
    if (bus_req.rd) begin
      n.rvalid = 1'b1;
      n.rdata  = 16'h0000;
      if (ch_sel < `TCC_NUM_CH) begin
        case (reg_sel)
          `TCC_REG_CTRL: n.rdata = {r.io_control_register[ch_sel], r.timer_control_register[ch_sel]};
          `TCC_REG_STAT: n.rdata = {13'h0000, r.timer_status_register[ch_sel]};
          `TCC_REG_CNT:  n.rdata = r.cnt[ch_sel];
          `TCC_REG_GRA:  n.rdata = r.general_register_a[ch_sel];
          `TCC_REG_GRB:  n.rdata = r.general_register_b[ch_sel];
          `TCC_REG_BRA:  n.rdata = (ch_sel >= 3'h3) ? r.buffer_register_a[~ch_sel[0]] : 16'h0000;
          `TCC_REG_BRB:  n.rdata = (ch_sel >= 3'h3) ? r.buffer_register_b[~ch_sel[0]] : 16'h0000;
          default:       n.rdata = 16'h0000;
        endcase
      end else if (ch_sel == `TCC_GLB_CH && reg_sel == `TCC_GLB_FUNC) begin
        n.rdata = {12'h000, r.bfen};
      end else if (ch_sel == `TCC_GLB_CH && reg_sel == `TCC_GLB_MODE) begin
        n.rdata = {3'h0, r.mode};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || standby) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence seq_cap_buf_a3;
    cpa[3] && buf_a[3] && !ch_wr[3];
  endsequence

  sequence seq_cmp_buf_a4;
    mat_a[4] && buf_a[4] && !ch_wr[4];
  endsequence

  chk_standby_zero: assert property (standby |=> r.cnt == '0 && r.buffer_register_a == ST_RST.buffer_register_a)
    else $error("counters or buffers not reset by standby");
  chk_standby_gr: assert property (standby |=> r.general_register_a == ST_RST.general_register_a && r.out_oe == '0)
    else $error("general registers not reset to compare state");
  chk_ch0_up: assert property (tick[0] && !clr[0] && !ch_wr[0] && !standby
                               |=> r.cnt[0] == $past(r.cnt[0]) + 16'h0001)
    else $error("channel 0 did not count up");
  chk_ch2_dir: assert property (!r.mode[`TCC_MODE_PHASE] |-> !dn[2])
    else $error("channel 2 counts down outside phase counting");
  chk_ch34_dir: assert property (!r.mode[`TCC_MODE_CPWM] |-> dn[4:3] == 2'h0)
    else $error("channels 3 or 4 count down outside complementary pwm");
  chk_wrap_up: assert property (tick[1] && !dn[1] && !clr[1] && r.cnt[1] == `TCC_CNT_ONES
                                && !standby |=> r.timer_status_register[1][`TCC_TSR_WRAP])
    else $error("wrap flag missed on up wrap");
  chk_wrap_down: assert property (tick[2] && dn[2] && !clr[2] && r.cnt[2] == 16'h0000
                                  && !standby |=> r.timer_status_register[2][`TCC_TSR_WRAP])
    else $error("wrap flag missed on down wrap");
  chk_clear_on_a: assert property (own_clr[1] && !ch_wr[1] && !standby
                                   |=> r.cnt[1] == 16'h0000)
    else $error("counter not cleared on match or capture");
  chk_match_flag: assert property (mat_b[1] && !standby |=> r.timer_status_register[1][`TCC_TSR_MCB])
    else $error("match flag not set");
  chk_capture_latch: assert property (cpa[3] && !ch_wr[3] && !standby
                                      |=> r.general_register_a[3] == $past(r.cnt[3])
                                          && r.timer_status_register[3][`TCC_TSR_MCA])
    else $error("capture did not latch counter and flag");
  // pwm channel 0 has no buffer, so only a cpu write may move its register
  chk_pwm_no_capture: assert property (pwm_any[0] && !ch_wr[0] && !standby
                                       |=> r.general_register_a[0] == $past(r.general_register_a[0]))
    else $error("capture taken in pwm mode");
  chk_capture_buffer: assert property (seq_cap_buf_a3 and !standby
                                       |=> r.buffer_register_a[0] == $past(r.general_register_a[3])
                                           && r.general_register_a[3] == $past(r.cnt[3]))
    else $error("capture buffer shift wrong");
  chk_compare_buffer: assert property (seq_cmp_buf_a4 and !standby
                                       |=> r.general_register_a[4] == $past(r.buffer_register_a[1]))
    else $error("compare buffer not transferred");

endmodule

`default_nettype wire

// file: pkg/tcc_consts.svh
// Purpose: offsets, field positions and reset values of the timer counter block
// Assumes: word index on the internal 16-bit bus, channel in addr[5:3]
// Notes:   register and field constants only
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_REG_CTRL      3'h0
`define TCC_REG_STAT      3'h1
`define TCC_REG_CNT       3'h2
`define TCC_REG_GRA       3'h3
`define TCC_REG_GRB       3'h4
`define TCC_REG_BRA       3'h5
`define TCC_REG_BRB       3'h6
`define TCC_GLB_CH        3'h5
`define TCC_GLB_FUNC      3'h0
`define TCC_GLB_MODE      3'h1
`define TCC_NUM_CH        3'h5
`define TCC_TSR_MCA       0
`define TCC_TSR_MCB       1
`define TCC_TSR_WRAP      2
`define TCC_TCR_EXT       2
`define TCC_TCR_EDGE_FALL 3
`define TCC_TCR_EDGE_BOTH 4
`define TCC_TCR_CLR_LO    5
`define TCC_TCR_CLR_HI    6
`define TCC_IO_CONTROL_REGISTER_CAP_A    2
`define TCC_IO_CONTROL_REGISTER_CAP_B    6
`define TCC_MODE_PHASE    5
`define TCC_MODE_CPWM     6
`define TCC_MODE_RSPWM    7
`define TCC_MODE_SYNC_LO  8
`define TCC_RST_CNT       16'h0000
`define TCC_RST_GR        16'hFFFF
`define TCC_RST_BR        16'hFFFF
`define TCC_RST_TCR       8'h80
`define TCC_RST_IO_CONTROL_REGISTER      8'h88
`define TCC_CNT_ONES      16'hFFFF
`endif

// file: pkg/tcc_pkg.sv
// Purpose: types of the timer counter block
// Assumes: five channels, buffers on channels 3 and 4
// Notes:   all block state lives in tcc_state_s
package tcc_pkg;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [1:0]  be;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } tcc_bus_req_s;

  typedef struct packed {
    logic [4:0][15:0] cnt;
    logic [4:0][15:0] general_register_a;
    logic [4:0][15:0] general_register_b;
    logic [1:0][15:0] buffer_register_a;
    logic [1:0][15:0] buffer_register_b;
    logic [4:0][7:0]  timer_control_register;
    logic [4:0][7:0]  io_control_register;
    logic [4:0][2:0]  timer_status_register;
    logic [3:0]       bfen;
    logic [12:0]      mode;
    logic [4:0]       down;
    logic [2:0]       presc;
    logic [13:0]      s1;
    logic [13:0]      s2;
    logic [13:0]      s3;
    logic [13:0]      lvl;
    logic [15:0]      rdata;
    logic             rvalid;
    logic [9:0]       out_lvl;
    logic [9:0]       out_oe;
  } tcc_state_s;
endpackage

// file: dv/tcc_pin_partner.sv
// Purpose: far side of the timer pins: capture and clock sources, compare loads
// Assumes: pins change on falling edges only
// Notes:   an undriven compare pin reads low, as through a pull-down
`timescale 1ns/10ps
`default_nettype none

module tcc_pin_partner (
  input  wire logic       clk_sys,
  output logic [3:0]      ext_clk_pin,
  output logic [4:0]      cap_a_pin,
  output logic [4:0]      cap_b_pin,
  input  wire logic [9:0] cmp_out,
  input  wire logic [9:0] cmp_oe,
  output logic [9:0]      pin_lvl
);
  initial begin
    ext_clk_pin = 4'h0;
    cap_a_pin = 5'h00;
    cap_b_pin = 5'h00;
  end

  // released pins fall to the pull-down level, never the last driven value
  assign pin_lvl = cmp_out & cmp_oe;

  ////////////////////////////////////////////////////////////////////////////
  // each level held 8 cycles so the sync stages and filter can agree
  task automatic cap_edge(input int ch);
    @(negedge clk_sys);
    cap_a_pin[ch] = ~cap_a_pin[ch];
    cap_b_pin[ch] = ~cap_b_pin[ch];
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic ext_edge(input int pin);
    @(negedge clk_sys);
    ext_clk_pin[pin] = ~ext_clk_pin[pin];
    repeat (8) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: dv/tb_timer_counter_compare_capture.sv
// Purpose: self-checking bench of the timer counter block
// Assumes: inputs change on falling edges; read data one cycle after rd
// Notes:   free-running counts are judged in windows, not exact values
`timescale 1ns/10ps
`include "tcc_consts.svh"
`default_nettype none

module tb_timer_counter_compare_capture
  import tcc_pkg::*;
();
  logic         clk_sys;
  logic         reset;
  logic         standby;
  tcc_bus_req_s bus_req;
  logic [15:0]  bus_rdata;
  logic         bus_rvalid;
  logic [3:0]   ext_clk_pin;
  logic [4:0]   cap_a_pin;
  logic [4:0]   cap_b_pin;
  logic [9:0]   cmp_out;
  logic [9:0]   cmp_oe;
  logic [9:0]   pin_lvl;
  logic [15:0]  lfsr_r;
  logic [15:0]  v;
  logic [15:0]  mdl;
  int           bad_count;
  int           comparisons;
  int           cycles;

  tcc_top dut_u (.clk_sys(clk_sys), .reset(reset), .standby(standby), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ext_clk_pin(ext_clk_pin),
    .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin), .cmp_out(cmp_out), .cmp_oe(cmp_oe));

  tcc_pin_partner partner_u (.clk_sys(clk_sys), .ext_clk_pin(ext_clk_pin),
    .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin), .cmp_out(cmp_out), .cmp_oe(cmp_oe),
    .pin_lvl(pin_lvl));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk_sys);
    bus_req = '{rd: 1'b0, wr: 1'b1, be: be, addr: a, wdata: d};
    @(negedge clk_sys);
    bus_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    bus_req.rd = 1'b1;
    bus_req.addr = a;
    @(posedge clk_sys);
    #1;
    d = bus_rdata;
    check("rvalid", {15'h0000, bus_rvalid}, 16'h0001);
    @(negedge clk_sys);
    bus_req.rd = 1'b0;
  endtask

  task automatic rc(input logic [5:0] a, input logic [15:0] exp, input string name);
    logic [15:0] d;
    rd(a, d);
    check(name, d, exp);
  endtask

  task automatic reset_vals();
    for (int c = 0; c < 5; c++) begin
      rc({c[2:0], `TCC_REG_CTRL}, 16'h8880, "control");
      rc({c[2:0], `TCC_REG_GRA}, 16'hFFFF, "gen a");
      rc({c[2:0], `TCC_REG_GRB}, 16'hFFFF, "gen b");
      rc({c[2:0], `TCC_REG_BRA}, (c > 2) ? 16'hFFFF : 16'h0000, "buf a");
      rc({c[2:0], `TCC_REG_BRB}, (c > 2) ? 16'hFFFF : 16'h0000, "buf b");
      rc({c[2:0], `TCC_REG_STAT}, 16'h0000, "status");
    end
    rd({3'h4, `TCC_REG_CNT}, v);
    check("cnt after reset", {15'h0000, v < 16'h0100}, 16'h0001);
    check("pins idle", {6'h00, pin_lvl}, 16'h0000);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // whole run needs about 530 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    standby = 1'b0;
    bus_req = '0;
    lfsr_r = 16'h000B;
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    reset_vals();
    // up wrap with general registers still all ones: wrap and both matches
    wr({3'h1, `TCC_REG_CNT}, 2'b11, 16'hFFFF);
    repeat (6) @(negedge clk_sys);
    rc({3'h1, `TCC_REG_STAT}, 16'h0007, "up wrap flags");
    // word then byte writes against the model
    for (int c = 0; c < 5; c++) begin
      lfsr_r = lfsr_next(lfsr_r);
      mdl = lfsr_r;
      wr({c[2:0], `TCC_REG_GRB}, 2'b11, mdl);
      lfsr_r = lfsr_next(lfsr_r);
      wr({c[2:0], `TCC_REG_GRB}, {c[0], ~c[0]}, lfsr_r);
      mdl = c[0] ? {lfsr_r[15:8], mdl[7:0]} : {mdl[15:8], lfsr_r[7:0]};
      rc({c[2:0], `TCC_REG_GRB}, mdl, "byte write");
    end
    rc(6'h38, 16'h0000, "unmapped");
    // clear on gen a match keeps the counter within 0..gen a
    wr({3'h1, `TCC_REG_GRA}, 2'b11, 16'h0010);
    wr({3'h1, `TCC_REG_CTRL}, 2'b01, 16'h0020);
    // start below gen a, else the first match is a full wrap away
    wr({3'h1, `TCC_REG_CNT}, 2'b11, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      repeat (lfsr_r[4:0]) @(negedge clk_sys);
      rd({3'h1, `TCC_REG_CNT}, v);
      check("cleared cnt", {15'h0000, v <= 16'h0010}, 16'h0001);
    end
    // divide by 8: exactly ten ticks in the eighty edges after the write
    wr({3'h0, `TCC_REG_CTRL}, 2'b01, 16'h0003);
    wr({3'h0, `TCC_REG_CNT}, 2'b11, 16'h0000);
    repeat (79) @(negedge clk_sys);
    rd({3'h0, `TCC_REG_CNT}, v);
    check("phi/8 count", v, 16'h000A);
    // phase counting down from zero wraps to all ones
    wr({`TCC_GLB_CH, `TCC_GLB_MODE}, 2'b11, 16'h0020);
    wr({3'h2, `TCC_REG_CNT}, 2'b11, 16'h0000);
    partner_u.ext_edge(1);
    partner_u.ext_edge(0);
    partner_u.ext_edge(0);
    rc({3'h2, `TCC_REG_CNT}, 16'hFFFF, "down count");
    rd({3'h2, `TCC_REG_STAT}, v);
    check("down wrap", v & 16'h0004, 16'h0004);
    // buffered capture on channel 3 gen a
    wr({`TCC_GLB_CH, `TCC_GLB_FUNC}, 2'b11, 16'h0001);
    wr({3'h3, `TCC_REG_GRA}, 2'b11, 16'h1234);
    wr({3'h3, `TCC_REG_CTRL}, 2'b10, 16'h8C00);
    wr({3'h3, `TCC_REG_CNT}, 2'b11, 16'h0000);
    partner_u.cap_edge(3);
    rc({3'h3, `TCC_REG_BRA}, 16'h1234, "capture buffer");
    rd({3'h3, `TCC_REG_GRA}, v);
    // pin moves 2 edges after the count write, three sync stages, capture one later
    check("captured cnt", v, 16'h0004);
    rd({3'h3, `TCC_REG_STAT}, v);
    check("capture flag", v & 16'h0001, 16'h0001);
    // buffered compare on channel 4 gen a, output driven high at match
    wr({`TCC_GLB_CH, `TCC_GLB_FUNC}, 2'b11, 16'h0005);
    wr({3'h4, `TCC_REG_BRA}, 2'b11, 16'h0050);
    wr({3'h4, `TCC_REG_GRA}, 2'b11, 16'h0020);
    wr({3'h4, `TCC_REG_CTRL}, 2'b10, 16'h8A00);
    wr({3'h4, `TCC_REG_CNT}, 2'b11, 16'h0000);
    repeat (48) @(negedge clk_sys);
    rc({3'h4, `TCC_REG_GRA}, 16'h0050, "compare buffer");
    check("compare pin", {15'h0000, pin_lvl[4]}, 16'h0001);
    // pwm on channel 0 must ignore the capture setting
    wr({`TCC_GLB_CH, `TCC_GLB_MODE}, 2'b11, 16'h0021);
    wr({3'h0, `TCC_REG_GRA}, 2'b11, 16'h4321);
    wr({3'h0, `TCC_REG_CTRL}, 2'b10, 16'h8C00);
    partner_u.cap_edge(0);
    rc({3'h0, `TCC_REG_GRA}, 16'h4321, "pwm no capture");
    // standby acts as a full reset
    @(negedge clk_sys);
    standby = 1'b1;
    repeat (2) @(negedge clk_sys);
    standby = 1'b0;
    reset_vals();
    // external clock C on channel 1, both edges counted
    wr({3'h1, `TCC_REG_CTRL}, 2'b01, 16'h0016);
    wr({3'h1, `TCC_REG_CNT}, 2'b11, 16'h0000);
    partner_u.ext_edge(2);
    partner_u.ext_edge(2);
    rc({3'h1, `TCC_REG_CNT}, 16'h0002, "ext both edges");
    // complementary pwm on channel 3: up to gen a plus one, then down
    wr({`TCC_GLB_CH, `TCC_GLB_MODE}, 2'b11, 16'h0040);
    wr({3'h3, `TCC_REG_GRA}, 2'b11, 16'h0004);
    wr({3'h3, `TCC_REG_CNT}, 2'b11, 16'h0000);
    repeat (7) @(negedge clk_sys);
    rc({3'h3, `TCC_REG_CNT}, 16'h0002, "cpwm down count");
    wrap_up();
  end
endmodule
`default_nettype wire
